// ===== hpc_clkdiv.sv
// Shared constants and the divide-by-128 slow clock enable generator
`timescale 1ns/1ps

package hpc_pkg;
	// ------------------------------------------------------------
	// Register map and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTL    = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_CLEAR  = 8'h18;
	localparam int CTL_WIDTH      = 8;
	localparam int CTL_SLEEP_REQ  = 1;
	localparam int CTL_CLK_SEL    = 2;
	localparam int CTL_MATCH_EN   = 3;
	localparam int CTL_PIN_EN     = 4;
	localparam int CTL_LOW_DET_EN = 5;
	localparam int CTL_CLK_EN     = 6;
	localparam int CTL_ABORT_EN   = 7;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam int ST_WIDTH  = 3;
	localparam int ST_MATCH  = 0;
	localparam int ST_LOW    = 1;
	localparam int ST_PIN    = 2;
	localparam logic [2:0] ST_RESET = 3'h0;
	// ------------------------------------------------------------
	// Clocking and sequencing counts
	// ------------------------------------------------------------
	localparam int XTAL_DIV       = 128;
	localparam int POR_HOLD_TICKS = 4;
	localparam logic SRC_XTAL     = 1'b0;
	localparam logic SRC_OSC      = 1'b1;
	typedef enum logic [1:0] {
		S_RUN,
		S_HIB,
		S_RESTORE
	} hpc_state_t;
endpackage

module hpc_clkdiv #(
	parameter int DIV = hpc_pkg::XTAL_DIV
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// Divider control
	input  wire logic enable,
	input  wire logic in_tick,
	// One-cycle output enable
	output logic      tick
);
	localparam int CW = $clog2(DIV);
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic          next_tick;

	// Count input edges; cleared while stopped so restart is aligned
	always_comb begin
		next_cnt  = cnt;
		next_tick = 1'b0;
		if (!enable) begin
			next_cnt = '0;
		end else if (in_tick) begin
			if (cnt == CW'(DIV - 1)) begin
				next_cnt  = '0;
				next_tick = 1'b1;
			end else begin
				next_cnt = cnt + 1'b1;
			end
		end
	end

	// Register the count and the enable pulse
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			tick <= next_tick;
		end
	end

	a_div_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tick |-> $past(cnt) == CW'(DIV - 1) && $past(in_tick))
		else $error("divider pulse not on the last input edge");
endmodule

// ===== hpc_power_ctl.sv
// Always-on hibernation power sequencer with its register port
//
// Function
// - Power-off pin asserted throughout hibernate state
// - Resume pin low ends hibernation
// - Compare match ends hibernation
// - Wake releases power-off pin, regulator restarts
// - Wake leads to full processor reset
// - Back-to-back reads need no spacing
// - Crystal path divides input by 128
// - Slow clock runs only when enabled
// - Select bit: 0 crystal, 1 oscillator
// - Detect supply below low threshold
// - Enabled detect sets low-supply status flag
// - Abort enable blocks hibernation on low supply
// - No supply checks while hibernating
// - Software enables wake source, then requests sleep
// - Separate pin and match wake enables
// - Event sources OR into one request
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module hpc_power_ctl
#(
	parameter int POR_HOLD = hpc_pkg::POR_HOLD_TICKS
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Pins
	input  wire logic        osc_in,
	input  wire logic        wake_n,
	output logic             power_off_request_n_out,
	output logic             power_off_request_n_oe,
	// System side
	input  wire logic        rtc_match,
	input  wire logic        low_supply_in,
	output logic             irq,
	output logic             core_reset_n
);
	import hpc_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic strobe,
		input logic [7:0] addr, input logic [7:0] off);
		hit = strobe && (addr == off);
	endfunction

	localparam int PW = $clog2(POR_HOLD + 1);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	hpc_state_t           state;
	hpc_state_t           next_state;
	logic [CTL_WIDTH-1:0] ctl;
	logic [CTL_WIDTH-1:0] next_ctl;
	logic [CTL_WIDTH-1:0] pend;
	logic [CTL_WIDTH-1:0] next_pend;
	logic                 pend_v;
	logic                 next_pend_v;
	logic [ST_WIDTH-1:0]  status;
	logic [ST_WIDTH-1:0]  next_status;
	logic [PW-1:0]        por_cnt;
	logic [PW-1:0]        next_por_cnt;
	logic [31:0]          next_rdata;
	logic                 osc_q;
	logic                 osc_edge;
	logic                 div_tick;
	logic                 slow_tick;
	logic                 sleep_try;
	logic                 sleep_block;
	logic                 wake_evt;
	logic                 low_seen;
	logic                 next_irq;
	logic                 next_off_oe;
	logic                 next_core_rst_n;

	// ------------------------------------------------------------
	// Slow clock source
	// ------------------------------------------------------------
	// Rising edges of the source pin form the base enable
	assign osc_edge = osc_in && !osc_q;

	hpc_clkdiv #(
		.DIV     (XTAL_DIV)
	) u_div (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.enable  (ctl[CTL_CLK_EN] && ctl[CTL_CLK_SEL] == SRC_XTAL),
		.in_tick (osc_edge),
		.tick    (div_tick)
	);

	// Source select and gating; the crystal needs settle time before
	// software may touch anything else, the oscillator does not
	assign slow_tick = ctl[CTL_CLK_EN] &&
		((ctl[CTL_CLK_SEL] == SRC_OSC) ? osc_edge : div_tick);

	// ------------------------------------------------------------
	// Sequencing conditions
	// ------------------------------------------------------------
	// Low supply only counts outside hibernation
	assign low_seen = ctl[CTL_LOW_DET_EN] && low_supply_in
		&& state != S_HIB;
	assign sleep_try = slow_tick && state == S_RUN
		&& ctl[CTL_SLEEP_REQ];
	// Refuse with no wake source, or on low supply when aborting
	assign sleep_block = !(ctl[CTL_PIN_EN] || ctl[CTL_MATCH_EN])
		|| (ctl[CTL_ABORT_EN] && low_seen);
	assign wake_evt = (ctl[CTL_PIN_EN] && !wake_n)
		|| (ctl[CTL_MATCH_EN] && rtc_match);

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	// Clock bits act at once, since nothing ticks until they do; the
	// rest is staged and moved on a slow tick. A second write before
	// that tick replaces the first, which is why writes need spacing.
	always_comb begin
		next_ctl    = ctl;
		next_pend   = pend;
		next_pend_v = pend_v;
		if (sleep_try) begin
			next_ctl[CTL_SLEEP_REQ] = 1'b0; // self-clears taken or not
		end
		if (slow_tick && pend_v) begin
			next_ctl    = pend;
			next_pend_v = 1'b0;
			next_ctl[CTL_CLK_EN]  = ctl[CTL_CLK_EN];
			next_ctl[CTL_CLK_SEL] = ctl[CTL_CLK_SEL];
		end
		if (hit(reg_wr, reg_addr, ADDR_CTL)) begin
			next_pend   = reg_wdata[CTL_WIDTH-1:0];
			next_pend_v = 1'b1;
			next_ctl[CTL_CLK_EN]  = reg_wdata[CTL_CLK_EN];
			next_ctl[CTL_CLK_SEL] = reg_wdata[CTL_CLK_SEL];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctl    <= CTL_RESET;
			pend   <= CTL_RESET;
			pend_v <= 1'b0;
			osc_q  <= 1'b0;
		end else begin
			ctl    <= next_ctl;
			pend   <= next_pend;
			pend_v <= next_pend_v;
			osc_q  <= osc_in;
		end
	end

	// ------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------
	// The restore phase holds the processor in reset for a fixed
	// number of slow ticks, so it needs the slow clock running
	always_comb begin
		next_state   = state;
		next_por_cnt = por_cnt;
		case (state)
			S_RUN: begin
				if (sleep_try && !sleep_block) begin
					next_state = S_HIB;
				end
			end
			S_HIB: begin
				if (wake_evt) begin
					next_state   = S_RESTORE;
					next_por_cnt = '0;
				end
			end
			S_RESTORE: begin
				if (slow_tick) begin
					if (por_cnt == PW'(POR_HOLD - 1)) begin
						next_state = S_RUN;
					end else begin
						next_por_cnt = por_cnt + 1'b1;
					end
				end
			end
			default: begin
				next_state = S_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state   <= S_RUN;
			por_cnt <= '0;
		end else begin
			state   <= next_state;
			por_cnt <= next_por_cnt;
		end
	end

	// ------------------------------------------------------------
	// Event status, clear and outputs
	// ------------------------------------------------------------
	// Write-one-to-clear; a new event in the same cycle wins
	always_comb begin
		next_status = status;
		if (hit(reg_wr, reg_addr, ADDR_CLEAR)) begin
			next_status = status & ~reg_wdata[ST_WIDTH-1:0];
		end
		if (rtc_match) begin
			next_status[ST_MATCH] = 1'b1;
		end
		if (low_seen) begin
			next_status[ST_LOW] = 1'b1;
		end
		if (!wake_n) begin
			next_status[ST_PIN] = 1'b1;
		end
		next_irq        = |next_status;
		next_off_oe     = next_state == S_HIB;
		next_core_rst_n = next_state == S_RUN;
		next_rdata      = '0;
		if (hit(reg_rd, reg_addr, ADDR_CTL)) begin
			next_rdata = {24'h000000, ctl};
		end else if (hit(reg_rd, reg_addr, ADDR_STATUS)) begin
			next_rdata = {29'h00000000, status};
		end
	end

	// Open drain: the driven value is always low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			status                  <= ST_RESET;
			irq                     <= 1'b0;
			reg_rdata               <= 32'h00000000;
			power_off_request_n_out <= 1'b0;
			power_off_request_n_oe  <= 1'b0;
			core_reset_n            <= 1'b1;
		end else begin
			status                  <= next_status;
			irq                     <= next_irq;
			reg_rdata               <= next_rdata;
			power_off_request_n_out <= 1'b0;
			power_off_request_n_oe  <= next_off_oe;
			core_reset_n            <= next_core_rst_n;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Control bits that act at once rather than on a slow tick
	localparam logic [7:0] CTL_CLK_BITS =
		(8'h01 << CTL_CLK_EN) | (8'h01 << CTL_CLK_SEL);

	sequence s_pin_wake;
		state == S_HIB && ctl[CTL_PIN_EN] && !wake_n;
	endsequence
	// Pin released and processor held in the cycle after the wake
	sequence s_restore_held;
		state == S_RESTORE && !core_reset_n && !power_off_request_n_oe;
	endsequence

	a_off_in_hib: assert property (
		(state == S_HIB) == power_off_request_n_oe)
		else $error("power-off pin does not follow hibernate state");
	a_pin_wake: assert property (s_pin_wake |=>
		s_restore_held)
		else $error("resume pin did not end hibernation");
	a_match_wake: assert property (
		state == S_HIB && ctl[CTL_MATCH_EN] && rtc_match |=> ##1
		!power_off_request_n_oe)
		else $error("match did not release power-off pin");
	a_off_release: assert property (
		$fell(power_off_request_n_oe) |-> $past(state) == S_HIB
		&& $past(wake_evt))
		else $error("power-off released without wake");
	a_por_after_wake: assert property (
		$fell(power_off_request_n_oe) |-> !core_reset_n ##1
		(!core_reset_n || $past(slow_tick)))
		else $error("processor not held in reset after wake");
	a_read_data: assert property (
		hit(reg_rd, reg_addr, ADDR_STATUS) |=>
		reg_rdata == {29'h00000000, $past(status)})
		else $error("status read data wrong or late");
	a_read_idle: assert property (!reg_rd |=> reg_rdata == '0)
		else $error("read data outside the answer cycle");
	a_clk_gate: assert property (
		!ctl[CTL_CLK_EN] |-> !slow_tick)
		else $error("slow tick while clock disabled");
	a_src_select: assert property (
		ctl[CTL_CLK_EN] && ctl[CTL_CLK_SEL] == SRC_OSC |->
		slow_tick == osc_edge)
		else $error("oscillator path not selected");
	a_low_flag: assert property (
		ctl[CTL_LOW_DET_EN] && low_supply_in && state == S_RUN |=>
		status[ST_LOW] && irq)
		else $error("low supply flag not set");
	a_low_abort: assert property (
		sleep_try && ctl[CTL_ABORT_EN] && low_seen |=>
		state == S_RUN && !ctl[CTL_SLEEP_REQ])
		else $error("hibernation entered on low supply");
	a_no_check_hib: assert property (
		state == S_HIB && !status[ST_LOW] |=> !status[ST_LOW])
		else $error("supply checked while hibernating");
	a_irq_or: assert property (irq == |status)
		else $error("interrupt request is not the OR of events");
	a_write_sync: assert property (
		!slow_tick |=> (ctl & ~CTL_CLK_BITS) ==
		($past(ctl) & ~CTL_CLK_BITS))
		else $error("control changed without a slow tick");
endmodule

// ===== hpc_partner.sv
// Far-side model: regulator on the power-off pin, wake pin, slow source
`timescale 1ns/1ps

module hpc_partner #(
	parameter int HALF_NS = 50
) (
	// Open-drain pin from the device
	input  wire logic pin_out,
	input  wire logic pin_oe,
	// Bench control of the wake button
	input  wire logic press,
	// Toward the device and the bench
	output logic      osc_in,
	output logic      wake_n,
	output logic      supply_on
);
	// Pull-up wins unless the device pulls the pin low
	assign supply_on = pin_oe ? pin_out : 1'b1;
	// Weak pull-up on the wake pin; the button shorts it low
	assign wake_n = press ? 1'b0 : 1'b1;
	// Source runs free, even when the counter is unused
	initial begin
		osc_in = 1'b0;
		forever #(HALF_NS) osc_in = ~osc_in;
	end
endmodule

// ===== tb_hibernate_power_control.sv
// Self-checking bench for the hibernation power sequencer
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin err_count++; \
	$display("Error %s expected %0h seen %0h", n, e, a); end end

module tb_hibernate_power_control;
	import hpc_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clk_sys, rst_n, reg_wr, reg_rd, press;
	logic        rtc_match, low_supply_in, osc_in, wake_n, supply_on;
	logic        pin_out, pin_oe, irq, core_reset_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd_val;
	int          err_count, n_compared, cyc, tcount, tot;
	// Source period in system cycles; the pass window spans three periods
	localparam int SRC_CYC = 10;
	localparam int SETTLE  = 100; // stands in for the crystal settle wait
	localparam int XTAL_HI = (2 * XTAL_DIV + 1) * SRC_CYC;
	localparam int XTAL_LO = (2 * XTAL_DIV - 2) * SRC_CYC;

	// POR hold shortened to one slow tick to keep the run brief
	hpc_power_ctl #(.POR_HOLD(1)) i_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .osc_in(osc_in), .wake_n(wake_n),
		.power_off_request_n_out(pin_out),
		.power_off_request_n_oe(pin_oe), .rtc_match(rtc_match),
		.low_supply_in(low_supply_in), .irq(irq),
		.core_reset_n(core_reset_n));
	// Source period of ten system cycles, toggling on clk_sys falling edges
	hpc_partner #(.HALF_NS(50)) i_partner (
		.pin_out(pin_out), .pin_oe(pin_oe), .press(press),
		.osc_in(osc_in), .wake_n(wake_n), .supply_on(supply_on));

	// ------------------------------------------------------------
	// Clock, timeout and bus tasks
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Whole run needs well under ten thousand cycles
	always @(posedge clk_sys) begin
		tcount++;
		if (tcount == 20000) begin
			err_count++;
			final_report();
		end
	end
	task final_report;
		$display("Counts: %0d compared, %0d mismatched", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe edge
	task rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask
	task wait_oe(input logic v, input int lim);
		cyc = 0;
		while (pin_oe !== v && cyc < lim) begin
			@(posedge clk_sys);
			#1;
			cyc++;
		end
	endtask
	task wait_rst(input int lim);
		cyc = 0;
		while (core_reset_n !== 1'b1 && cyc < lim) begin
			@(posedge clk_sys);
			#1;
			cyc++;
		end
	endtask
	task push(input int n);
		@(posedge clk_sys);
		press <= 1'b1;
		repeat (n) @(posedge clk_sys);
		press <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_reset;
		rd(ADDR_CTL);
		`CHK("ctl", CTL_RESET, rd_val[7:0])
		rd(ADDR_STATUS);
		`CHK("status", ST_RESET, rd_val[2:0])
		rd(8'h3C);
		`CHK("unmapped", 32'h0, rd_val)
		`CHK("oe", 1'b0, pin_oe)
		`CHK("core_reset_n", 1'b1, core_reset_n)
		`CHK("irq", 1'b0, irq)
		$display("test reset done");
	endtask
	// Source off: a sleep request must never be acted on
	task t_gate;
		wr(ADDR_CTL, 32'h1A);
		repeat (300) @(posedge clk_sys);
		`CHK("oe gated", 1'b0, pin_oe)
		$display("test gate done");
	endtask
	// Crystal path: enable, let it settle, then stage the request; it
	// lands on the first divided tick and is acted on at the second
	task t_xtal;
		wr(ADDR_CTL, 32'h40);
		repeat (SETTLE) @(posedge clk_sys);
		wr(ADDR_CTL, 32'h52);
		wait_oe(1'b1, 3000);
		tot = cyc + SETTLE + 2; // cycles since the enable write
		`CHK("xtal", 1'b1, tot > XTAL_LO && tot <= XTAL_HI)
		`CHK("supply off", 1'b0, supply_on)
		`CHK("core held", 1'b0, core_reset_n)
		push(4);
		wait_oe(1'b0, 5);
		`CHK("pin wake", 1'b0, pin_oe)
		wait_rst(3000);
		`CHK("por end", 1'b1, core_reset_n)
		rd(ADDR_STATUS);
		`CHK("pin flag", 3'h4, rd_val[2:0])
		wr(ADDR_CLEAR, 32'h4);
		rd(ADDR_STATUS);
		`CHK("cleared", 3'h0, rd_val[2:0])
		`CHK("irq off", 1'b0, irq)
		$display("test crystal done");
	endtask
	task t_osc;
		wr(ADDR_CTL, 32'h44);
		// Let the staged bits land on a source edge before reading back
		repeat (12) @(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= ADDR_CTL;
		@(posedge clk_sys);
		reg_addr <= 8'h3C;
		#1;
		`CHK("rd first", 8'h44, reg_rdata[7:0])
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		`CHK("rd second", 32'h0, reg_rdata)
		repeat (30) @(posedge clk_sys);
		wr(ADDR_CTL, 32'h4E);
		wait_oe(1'b1, 40);
		`CHK("osc sleep", 1'b1, pin_oe)
		push(5);
		repeat (30) @(posedge clk_sys);
		`CHK("pin disabled", 1'b1, pin_oe)
		@(posedge clk_sys);
		rtc_match <= 1'b1;
		@(posedge clk_sys);
		rtc_match <= 1'b0;
		wait_oe(1'b0, 4);
		`CHK("match wake", 1'b0, pin_oe)
		wait_rst(40);
		`CHK("supply on", 1'b1, supply_on)
		rd(ADDR_STATUS);
		`CHK("events", 3'h5, rd_val[2:0])
		`CHK("irq or", 1'b1, irq)
		wr(ADDR_CLEAR, 32'h7);
		rd(ADDR_STATUS);
		`CHK("cleared", 3'h0, rd_val[2:0])
		$display("test oscillator done");
	endtask
	task t_low;
		@(posedge clk_sys);
		low_supply_in <= 1'b1;
		wr(ADDR_CTL, 32'h64);
		repeat (40) @(posedge clk_sys);
		rd(ADDR_STATUS);
		`CHK("low flag", 1'b1, rd_val[ST_LOW])
		`CHK("low irq", 1'b1, irq)
		wr(ADDR_CTL, 32'hF6);
		repeat (60) @(posedge clk_sys);
		`CHK("abort", 1'b0, pin_oe)
		rd(ADDR_CTL);
		`CHK("req dropped", 1'b0, rd_val[CTL_SLEEP_REQ])
		@(posedge clk_sys);
		low_supply_in <= 1'b0;
		wr(ADDR_CLEAR, 32'h7);
		repeat (30) @(posedge clk_sys);
		wr(ADDR_CTL, 32'hF6);
		wait_oe(1'b1, 60);
		`CHK("sleep ok", 1'b1, pin_oe)
		@(posedge clk_sys);
		low_supply_in <= 1'b1;
		repeat (40) @(posedge clk_sys);
		rd(ADDR_STATUS);
		`CHK("no check", 1'b0, rd_val[ST_LOW])
		@(posedge clk_sys);
		low_supply_in <= 1'b0;
		push(4);
		wait_oe(1'b0, 5);
		`CHK("wake", 1'b0, pin_oe)
		$display("test low supply done");
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		press = 1'b0;
		rtc_match = 1'b0;
		low_supply_in = 1'b0;
		err_count = 0;
		n_compared = 0;
		tcount = 0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_gate();
		t_xtal();
		t_osc();
		t_low();
		final_report();
	end
endmodule
